// [dv/dtsi_link_properties.sv]
// concurrent checks on the link joining gateway and receiver
`timescale 1ns/1ps
`default_nettype none

module dtsi_link_properties
  import dtsi_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link signals
  input wire logic frame_valid,
  input wire dtsi_en_e enable,
  input wire dtsi_sw_e primary,
  input wire dtsi_sw_e secondary,
  input wire logic [1:0] alive,
  // receiver outputs
  input wire logic o_gear_up,
  input wire logic o_gear_down,
  input wire logic o_range_up,
  input wire logic o_range_down,
  input wire logic o_shift_active,
  input wire logic o_range_active,
  input wire logic o_fault,
  input wire logic o_comm_lost
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic had;
  logic [1:0] last_alive;
  logic steps;
  assign steps = o_gear_up | o_gear_down | o_range_up | o_range_down;

  // last frame count; reset restarts the sequence at zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      had <= 1'b0;
      last_alive <= 2'h0;
    end else if (frame_valid) begin
      had <= 1'b1;
      last_alive <= alive;
    end
  end

  a_first_alive: assert property (
    frame_valid && !had |-> alive == 2'h0)
    else $error("first frame count not zero");
  a_alive_rolls: assert property (frame_valid && had |->
    alive == last_alive + 2'h1) else $error("rolling count skipped");
  a_fields_hold: assert property (!frame_valid |->
    $stable({enable, primary, secondary, alive}))
    else $error("fields moved between frames");
  a_step_cause: assert property (steps |->
    $past(frame_valid) || $past(frame_valid, 2))
    else $error("step without a frame");
  a_no_up_down: assert property (!(o_gear_up && o_gear_down) &&
    !(o_range_up && o_range_down)) else $error("up and down together");
  a_gear_shift: assert property ((o_gear_up || o_gear_down) |->
    o_shift_active && !o_range_up && !o_range_down)
    else $error("gear step outside shift feature");
  a_range_sel: assert property ((o_range_up || o_range_down) |->
    o_range_active) else $error("range step outside range feature");
  a_one_feature: assert property (
    !(o_shift_active && o_range_active)) else $error("both features active");
  a_fault_quiet: assert property (o_fault |-> !steps)
    else $error("step from illegal code");
  a_conflict_none: assert property (frame_valid &&
    ({primary, secondary} == 4'h6 || {primary, secondary} == 4'h9)
    |=> !steps) else $error("step from opposed switches");
  a_link_alive: assert property (
    frame_valid |-> ##[1:2] !o_comm_lost)
    else $error("loss flag held despite frame");
endmodule

`default_nettype wire

// [dv/dual_tap_switch_interpreter_tb.sv]
// self-checking bench for the dual tap switch interpreter
`timescale 1ns/1ps
`default_nettype none

module dual_tap_switch_interpreter_tb;
  import dtsi_pkg::*;
  // {enable, primary, secondary, count skew} corner frames
  localparam logic [7:0] CORNER [17] = '{8'h44, 8'h44, 8'h54, 8'h40, 8'h54,
    8'h58, 8'h40, 8'h48, 8'h4c, 8'h49, 8'h48, 8'h64, 8'h80, 8'ha0, 8'h90,
    8'h04, 8'hc8};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic ce_b = 1'b1;
  logic [1:0] g_en = 2'h0, g_pri = 2'h0, g_sec = 2'h0;
  logic sup = 1'b1, two = 1'b1;
  logic [8:0] oa, ob;
  logic [3:0] pc [9] = '{default: 4'h0};
  logic [5:0] g_last = 6'h00;
  logic [8:0] ev;
  logic [1:0] m_pri = 2'h0, m_sec = 2'h0, m_cnt = 2'h0;
  logic [2:0] m_lvl = 3'h0;
  logic m_seen = 1'b0;
  int failures = 0, n_checks = 0, cyc = 0;

  dtsi_if link_a();
  dtsi_if link_b();
  dtsi_gateway #(.SEND_PERIOD_CYC(16)) i_dtsi_gateway (.i_clk(clk),
    .i_rst(rst), .i_ce(ce), .i_enable(g_en), .i_primary(g_pri),
    .i_secondary(g_sec), .i_features_supported(sup), .i_two_sets(two),
    .link(link_a));
  dtsi_receiver #(.SILENCE_CYC(64)) i_dtsi_receiver (.i_clk(clk), .i_rst(rst),
    .i_ce(ce), .link(link_a), .o_gear_up(oa[0]), .o_gear_down(oa[1]),
    .o_range_up(oa[2]), .o_range_down(oa[3]), .o_shift_active(oa[4]),
    .o_range_active(oa[5]), .o_fault(oa[6]), .o_count_err(oa[7]),
    .o_comm_lost(oa[8]));
  // second receiver fed by the bench so it can break the count
  dtsi_receiver #(.SILENCE_CYC(64)) i_dtsi_receiver_2 (.i_clk(clk),
    .i_rst(rst), .i_ce(ce_b), .link(link_b), .o_gear_up(ob[0]),
    .o_gear_down(ob[1]), .o_range_up(ob[2]), .o_range_down(ob[3]),
    .o_shift_active(ob[4]), .o_range_active(ob[5]), .o_fault(ob[6]),
    .o_count_err(ob[7]), .o_comm_lost(ob[8]));
  dtsi_link_properties i_dtsi_link_properties (.i_clk(clk), .i_rst(rst),
    .frame_valid(link_a.frame_valid), .enable(link_a.enable),
    .primary(link_a.primary), .secondary(link_a.secondary),
    .alive(link_a.alive), .o_gear_up(oa[0]), .o_gear_down(oa[1]),
    .o_range_up(oa[2]), .o_range_down(oa[3]), .o_shift_active(oa[4]),
    .o_range_active(oa[5]), .o_fault(oa[6]), .o_comm_lost(oa[8]));

  always #20 clk = ~clk;

  // counted events: bench receiver steps and count errors, then link steps
  assign ev = {oa[3:0], ob[7], ob[3:0]};

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [3:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // pulse counters; counting avoids guessing the exact answer cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 9; k++) begin
      if (ev[k] === 1'b1) begin
        pc[k] <= pc[k] + 4'h1;
      end
    end
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  // expected {down, up} of a frame against the last accepted fields;
  // opposed or illegal codes cancel, a held value is no new press
  function automatic logic [1:0] step_exp(input logic [1:0] pri, sec,
      lpri, lsec);
    logic up, dn, off;
    off = pri == 2'h3 || sec == 2'h3 || {pri, sec} == 4'h6 ||
      {pri, sec} == 4'h9;
    up = (pri == 2'h1 && lpri != 2'h1) || (sec == 2'h1 && lsec != 2'h1);
    dn = (pri == 2'h2 && lpri != 2'h2) || (sec == 2'h2 && lsec != 2'h2);
    return {dn && !off, up && !off};
  endfunction

  // one frame on the bench link, then compare with the model
  task automatic send(input logic [1:0] en, pri, sec, sk);
    logic ok, ill;
    logic [1:0] al, st;
    logic [3:0] ex;
    logic [3:0] p0 [9];
    p0 = pc;
    al = m_cnt + 2'h1 + sk;
    ok = !m_seen || sk == 2'h0;
    ill = pri == 2'h3 || sec == 2'h3;
    st = ok ? step_exp(pri, sec, m_pri, m_sec) : 2'h0;
    ex = {st & {2{en == 2'h2}}, st & {2{en == 2'h1}}};
    @(negedge clk);
    link_b.frame_valid = 1'b1;
    link_b.enable = dtsi_en_e'(en);
    link_b.primary = dtsi_sw_e'(pri);
    link_b.secondary = dtsi_sw_e'(sec);
    link_b.alive = al;
    @(negedge clk);
    link_b.frame_valid = 1'b0;
    repeat (3) @(negedge clk);
    if (ok) begin
      m_seen = 1'b1;
      m_cnt = al;
      m_pri = pri;
      m_sec = sec;
      m_lvl = {ill, en == 2'h2, en == 2'h1};
    end
    check("count_err", pc[4] - p0[4], {3'h0, !ok});
    check("gear_up", pc[0] - p0[0], {3'h0, ex[0]});
    check("gear_dn", pc[1] - p0[1], {3'h0, ex[1]});
    check("range_up", pc[2] - p0[2], {3'h0, ex[2]});
    check("range_dn", pc[3] - p0[3], {3'h0, ex[3]});
    check("levels", {ob[8], ob[6:4]}, 4'(m_lvl));
  endtask

  // gateway inputs; a frame with the masked values must follow, and the
  // joined receiver must step and settle as that frame asks
  task automatic gw(input logic [1:0] en, pri, sec, input logic s, t);
    logic hit;
    logic [5:0] want;
    logic [1:0] st;
    logic [3:0] ex, lv;
    logic [3:0] p0 [9];
    p0 = pc;
    hit = 1'b0;
    want = s ? {en, pri, t ? sec : 2'h0} : 6'h00;
    st = step_exp(want[3:2], want[1:0], g_last[3:2], g_last[1:0]);
    ex = {st & {2{want[5:4] == 2'h2}}, st & {2{want[5:4] == 2'h1}}};
    lv = {1'b0, want[3:2] == 2'h3 || want[1:0] == 2'h3,
      want[5:4] == 2'h2, want[5:4] == 2'h1};
    @(negedge clk);
    g_en = en;
    g_pri = pri;
    g_sec = sec;
    sup = s;
    two = t;
    repeat (40) begin
      @(negedge clk);
      if (link_a.frame_valid === 1'b1 && {link_a.enable, link_a.primary,
          link_a.secondary} === want) begin
        hit = 1'b1;
      end
    end
    check("gateway_frame", {3'h0, hit}, 4'h1);
    check("link_levels", {oa[8] | oa[7], oa[6:4]}, lv);
    for (int k = 0; k < 4; k++) begin
      check("link_step", pc[k + 5] - p0[k + 5], {3'h0, ex[k]});
    end
    g_last = want;
  endtask

  initial begin
    void'($urandom(32'h01b7e84a));
    link_b.frame_valid = 1'b0;
    link_b.enable = DTSI_EN_OFF;
    link_b.primary = DTSI_SW_NONE;
    link_b.secondary = DTSI_SW_NONE;
    link_b.alive = 2'h0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    foreach (CORNER[i]) begin
      send(CORNER[i][7:6], CORNER[i][5:4], CORNER[i][3:2], CORNER[i][1:0]);
    end
    // frozen receiver keeps its silence timer, so no loss is flagged
    ce_b = 1'b0;
    repeat (80) @(negedge clk);
    check("frozen", {ob[8], ob[6:4]}, 4'(m_lvl));
    ce_b = 1'b1;
    // silence: loss flag, defaults restored, next count taken freely
    repeat (80) @(negedge clk);
    check("comm_lost", {ob[8], ob[6:4]}, 4'h8);
    m_seen = 1'b0;
    m_pri = 2'h0;
    m_sec = 2'h0;
    m_lvl = 3'h0;
    send(2'h1, 2'h0, 2'h1, 2'h3);
    repeat (300) begin
      send(2'($urandom), 2'($urandom), 2'($urandom),
        ($urandom % 4 == 0) ? 2'($urandom) : 2'h0);
    end
    gw(2'h1, 2'h1, 2'h2, 1'b1, 1'b1);
    gw(2'h1, 2'h1, 2'h2, 1'b0, 1'b1);
    gw(2'h1, 2'h0, 2'h1, 1'b1, 1'b0);
    repeat (40) begin
      gw(2'($urandom), 2'($urandom), 2'($urandom), 1'($urandom), 1'($urandom));
    end
    print_verdict();
  end
endmodule

`default_nettype wire

// [hw/dtsi_defines.svh]
// timing counts and frame constants for the dual tap switch interpreter
`ifndef DTSI_DEFINES_SVH
`define DTSI_DEFINES_SVH

// system clock rate in hertz
`define DTSI_CLK_HZ 25000000
// width of a switch field and of the alive rolling count
`define DTSI_FIELD_W 2
`define DTSI_ALIVE_W 2
// transmitter must get a switch change onto the link within this time
`define DTSI_SEND_DELAY_MS 40
// longest time rounds down to whole cycles
`define DTSI_SEND_DELAY_CYC ((`DTSI_SEND_DELAY_MS * `DTSI_CLK_HZ) / 1000)
// receiver output must follow an input change within this time
`define DTSI_ACT_DELAY_MS 50
`define DTSI_ACT_DELAY_CYC ((`DTSI_ACT_DELAY_MS * `DTSI_CLK_HZ) / 1000)
// width of the frame and silence timers, enough for either count
`define DTSI_TIMER_W 21

`endif

// [hw/dtsi_gateway.sv]
// transmitting end: packs debounced switch states into frames
`timescale 1ns/1ps
`default_nettype none
`include "dtsi_defines.svh"

module dtsi_gateway
  import dtsi_pkg::*;
#(
  parameter int SEND_PERIOD_CYC = `DTSI_SEND_DELAY_CYC
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // debounced switch states, same clock domain
  input wire logic [1:0] i_enable,
  input wire logic [1:0] i_primary,
  input wire logic [1:0] i_secondary,
  // application options
  input wire logic i_features_supported,
  input wire logic i_two_sets,
  // link
  dtsi_if.gateway link
);

  dtsi_tx_s r;
  dtsi_tx_s next_r;
  dtsi_en_e want_en;
  dtsi_sw_e want_pri;
  dtsi_sw_e want_sec;
  logic changed;
  logic period_up;

  // fields to send; unsupported builds send no activation
  always_comb begin
    want_en = dtsi_en_e'(i_enable); // RULE_13
    want_pri = dtsi_sw_e'(i_primary);
    want_sec = dtsi_sw_e'(i_secondary);
    if (!i_features_supported) begin
      want_en = DTSI_EN_OFF; // RULE_14
      want_pri = DTSI_SW_NONE;
      want_sec = DTSI_SW_NONE;
    end else if (!i_two_sets) begin
      want_sec = DTSI_SW_NONE; // RULE_14
    end
  end

  // a change goes out on the next edge, well inside the send bound
  assign changed = !r.sent_once || want_en != r.en || want_pri != r.pri ||
                   want_sec != r.sec; // RULE_15
  assign period_up = r.timer >= 21'(SEND_PERIOD_CYC - 1);

  // one frame carries all three fields and the count together
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    next_r.timer = r.timer + 21'h1;
    if (changed || period_up) begin
      next_r.valid = 1'b1; // RULE_05
      next_r.en = want_en;
      next_r.pri = want_pri;
      next_r.sec = want_sec; // RULE_18
      next_r.alive = r.cnt; // RULE_16
      next_r.cnt = r.cnt + 2'h1;
      next_r.sent_once = 1'b1;
      next_r.timer = 21'h0;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign link.frame_valid = r.valid;
  assign link.enable = r.en;
  assign link.primary = r.pri;
  assign link.secondary = r.sec;
  assign link.alive = r.alive;

endmodule

`default_nettype wire

// [hw/dtsi_if.sv]
// link between the gateway transmitter and the tap switch receiver
`timescale 1ns/1ps
`default_nettype none

interface dtsi_if;
  import dtsi_pkg::*;

  // one frame per cycle of frame_valid, all fields sampled together
  logic frame_valid;
  dtsi_en_e enable;
  dtsi_sw_e primary;
  dtsi_sw_e secondary;
  logic [1:0] alive;

  modport gateway (
    output frame_valid,
    output enable,
    output primary,
    output secondary,
    output alive
  );

  modport receiver (
    input frame_valid,
    input enable,
    input primary,
    input secondary,
    input alive
  );
endinterface

`default_nettype wire

// [hw/dtsi_pkg.sv]
// types shared by both ends of the dual tap switch link
package dtsi_pkg;

  // switch-state field encoding, 0..3 in declaration order
  typedef enum logic [1:0] {
    DTSI_SW_NONE,
    DTSI_SW_INC,
    DTSI_SW_DEC,
    DTSI_SW_ILLEGAL
  } dtsi_sw_e;

  // enable field encoding, 0..3 in declaration order
  typedef enum logic [1:0] {
    DTSI_EN_OFF,
    DTSI_EN_SHIFT,
    DTSI_EN_RANGE,
    DTSI_EN_BAD
  } dtsi_en_e;

  // receiving end state
  typedef struct packed {
    logic seen;
    logic [1:0] cnt;
    dtsi_en_e en;
    dtsi_sw_e pri;
    dtsi_sw_e sec;
    logic gear_up;
    logic gear_down;
    logic range_up;
    logic range_down;
    logic fault;
    logic count_err;
    logic comm_lost;
    logic shift_active;
    logic range_active;
    logic [20:0] timer;
  } dtsi_rx_s;

  // transmitting end state
  typedef struct packed {
    logic valid;
    dtsi_en_e en;
    dtsi_sw_e pri;
    dtsi_sw_e sec;
    logic [1:0] alive;
    logic [1:0] cnt;
    logic sent_once;
    logic [20:0] timer;
  } dtsi_tx_s;

endpackage

// [hw/dtsi_receiver.sv]
// receiving end: turns tap switch frames into gear and range steps
//
// Contract
// RULE_01 - switch fields are two bits, four codes
// RULE_02 - enable off disables both features, no steps
// RULE_03 - illegal secondary code faults, gives no step
// RULE_04 - active secondary combines both fields into steps
// RULE_05 - both fields come in one frame together
// RULE_06 - steps only on a field value change
// RULE_07 - same direction on both gives one step
// RULE_08 - opposite directions mean no activation
// RULE_09 - later single new press after conflict steps
// RULE_10 - idle primary needs fresh secondary transition
// RULE_11 - range feature uses same logic for range steps
// RULE_12 - secondary defaults none; output within 50 ms
// RULE_13 - transmitter sends debounced secondary state
// RULE_14 - unsupported builds always send no activation
// RULE_15 - transmitter delivers secondary change within 40 ms
// RULE_16 - frame carries 2-bit rolling count 0..3
// RULE_17 - count error keeps last accepted fields
// RULE_18 - count covers enable, primary and secondary capture
// RULE_19 - count must be previous plus one, first free
// RULE_20 - previous fields stored, updated on accepted frames
`timescale 1ns/1ps
`default_nettype none
`include "dtsi_defines.svh"

module dtsi_receiver
  import dtsi_pkg::*;
#(
  // silence longer than this is communication loss
  parameter int SILENCE_CYC = `DTSI_ACT_DELAY_CYC
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // link
  dtsi_if.receiver link,
  // gear step requests, one-cycle pulses
  output logic o_gear_up,
  output logic o_gear_down,
  // range step requests, one-cycle pulses
  output logic o_range_up,
  output logic o_range_down,
  // feature state, levels
  output logic o_shift_active,
  output logic o_range_active,
  // diagnostics
  output logic o_fault,
  output logic o_count_err,
  output logic o_comm_lost
);

  dtsi_rx_s r;
  dtsi_rx_s next_r;

  // decoded frame fields
  dtsi_en_e in_en;
  dtsi_sw_e in_pri;
  dtsi_sw_e in_sec;
  logic [1:0] in_cnt;

  // frame acceptance
  logic count_ok;
  logic accept;
  logic silent;

  // transitions and combined request
  logic pri_up_edge;
  logic pri_down_edge;
  logic sec_up_edge;
  logic sec_down_edge;
  logic conflict;
  logic want_up;
  logic want_down;
  logic illegal;

  // link fields come from logic on this clock, no synchroniser needed
  assign in_en = link.enable;
  assign in_pri = link.primary; // RULE_01
  assign in_sec = link.secondary; // RULE_01
  assign in_cnt = link.alive; // RULE_16

  // first frame after reset or silence is taken as the count base
  assign count_ok = !r.seen || in_cnt == r.cnt + 2'h1; // RULE_19
  assign accept = link.frame_valid && count_ok; // RULE_17
  assign silent = r.timer >= 21'(SILENCE_CYC - 1);

  // a step needs a value newly entering inc or dec; unchanged repeats
  // and the illegal code never count as a press
  assign pri_up_edge = in_pri == DTSI_SW_INC &&
                       r.pri != DTSI_SW_INC; // RULE_06
  assign pri_down_edge = in_pri == DTSI_SW_DEC &&
                         r.pri != DTSI_SW_DEC; // RULE_06
  assign sec_up_edge = in_sec == DTSI_SW_INC &&
                       r.sec != DTSI_SW_INC; // RULE_10
  assign sec_down_edge = in_sec == DTSI_SW_DEC &&
                         r.sec != DTSI_SW_DEC; // RULE_10

  // opposite directions in one frame cancel; held values count too,
  // so a press against a held opposite switch also cancels
  assign conflict = (in_pri == DTSI_SW_INC && in_sec == DTSI_SW_DEC) ||
                    (in_pri == DTSI_SW_DEC &&
                     in_sec == DTSI_SW_INC); // RULE_08

  // illegal code on either field faults and blocks any step
  assign illegal = in_sec == DTSI_SW_ILLEGAL ||
                   in_pri == DTSI_SW_ILLEGAL; // RULE_03

  // both fields judged jointly; either edge in a direction gives one
  // step only, however many fields show it
  always_comb begin
    want_up = 1'b0;
    want_down = 1'b0;
    if (!conflict && !illegal) begin // RULE_04
      want_up = pri_up_edge || sec_up_edge; // RULE_07
      want_down = pri_down_edge || sec_down_edge; // RULE_09
    end
  end

  // next state: pulses clear every cycle, fields move on accepted frames
  always_comb begin
    next_r = r;
    next_r.gear_up = 1'b0;
    next_r.gear_down = 1'b0;
    next_r.range_up = 1'b0;
    next_r.range_down = 1'b0;
    next_r.count_err = 1'b0;
    next_r.timer = r.timer + 21'h1;
    if (link.frame_valid) begin
      // any frame, good count or not, shows the link is alive
      next_r.timer = 21'h0;
      next_r.comm_lost = 1'b0;
      next_r.count_err = !count_ok; // RULE_17
    end else if (silent) begin
      // communication loss: fall back to no activation
      next_r.timer = r.timer;
      next_r.comm_lost = 1'b1;
      next_r.seen = 1'b0;
      next_r.en = DTSI_EN_OFF;
      next_r.pri = DTSI_SW_NONE;
      next_r.sec = DTSI_SW_NONE; // RULE_12
      next_r.fault = 1'b0;
      next_r.shift_active = 1'b0;
      next_r.range_active = 1'b0;
    end
    if (accept) begin
      // all fields of the frame are taken as one sample
      next_r.seen = 1'b1;
      next_r.cnt = in_cnt;
      next_r.en = in_en; // RULE_05
      next_r.pri = in_pri; // RULE_20
      next_r.sec = in_sec; // RULE_20
      next_r.fault = illegal; // RULE_03
      next_r.shift_active = in_en == DTSI_EN_SHIFT;
      next_r.range_active = in_en == DTSI_EN_RANGE;
      // steps are routed by the enabled feature; off gives none
      unique case (in_en)
        DTSI_EN_SHIFT: begin
          next_r.gear_up = want_up; // RULE_04
          next_r.gear_down = want_down; // RULE_04
        end
        DTSI_EN_RANGE: begin
          next_r.range_up = want_up; // RULE_11
          next_r.range_down = want_down; // RULE_11
        end
        DTSI_EN_OFF: begin
          next_r.gear_up = 1'b0; // RULE_02
          next_r.gear_down = 1'b0; // RULE_02
          next_r.range_up = 1'b0; // RULE_02
          next_r.range_down = 1'b0; // RULE_02
        end
        DTSI_EN_BAD: begin
          // unused enable code handled as off, the safe choice
          next_r.gear_up = 1'b0;
          next_r.gear_down = 1'b0;
          next_r.range_up = 1'b0;
          next_r.range_down = 1'b0;
        end
      endcase
    end
  end

  // state register; reset loads the power-up defaults, all none
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '0; // RULE_12
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // outputs straight from the state register, one cycle after the
  // frame, far inside the actuation bound
  assign o_gear_up = r.gear_up; // RULE_12
  assign o_gear_down = r.gear_down;
  assign o_range_up = r.range_up;
  assign o_range_down = r.range_down;
  assign o_shift_active = r.shift_active;
  assign o_range_active = r.range_active;
  assign o_fault = r.fault;
  assign o_count_err = r.count_err;
  assign o_comm_lost = r.comm_lost;

endmodule

`default_nettype wire
